// File: inc/asp_pkg.sv
// constants and types shared by both ends of the angle sensor command port
package asp_pkg;

  // ********************************************************
  // timing
  // ********************************************************
  localparam int CLK_MHZ       = 50;
  localparam int INIT_TIME_US  = 1000;
  localparam int INIT_CYC_DEF  = INIT_TIME_US * CLK_MHZ;
  localparam int SCLK_HALF_NS  = 500;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ) / 1000;

  // ********************************************************
  // widths and sizes
  // ********************************************************
  localparam int WORDS      = 16;
  localparam int WORD_W     = 16;
  localparam int ADDR_W     = 4;
  localparam int CMD_W      = 8;
  localparam int FRAME_W    = CMD_W + WORD_W;
  localparam int ANG_W      = 13;
  localparam int TMP_W      = 7;
  localparam int ERR_W      = 2;
  localparam int SMP_W      = ANG_W + TMP_W + 2;
  localparam int FIFO_DEPTH = 16;
  localparam int NV_BITS    = WORDS * WORD_W;

  // ********************************************************
  // pin positions in the synchroniser vector
  // ********************************************************
  localparam int PIN_CS  = 0;
  localparam int PIN_SCK = 1;
  localparam int PIN_DAT = 2;

  // ********************************************************
  // commands, error codes, configuration words
  // ********************************************************
  localparam logic [3:0] OP_WR = 4'h0;
  localparam logic [3:0] OP_RD = 4'h1;
  localparam logic [ERR_W-1:0] ERR_DIAG  = 2'h0;
  localparam logic [ERR_W-1:0] ERR_INPUT = 2'h1;
  localparam logic [ERR_W-1:0] ERR_TEMP  = 2'h2;
  localparam logic [ERR_W-1:0] ERR_NONE  = 2'h3;
  localparam logic [ADDR_W-1:0] ADR_ZERO  = 4'h2;
  localparam logic [ADDR_W-1:0] ADR_TEMP  = 4'h6;
  localparam logic [ADDR_W-1:0] ADR_CTRL1 = 4'h7;
  localparam int CTRL1_CPL_BIT = 4;
  localparam int ZERO_LSB      = 3;
  localparam logic [WORDS-1:0] PROT_MASK = 16'h7c23;
  localparam logic [NV_BITS-1:0] NV_DEFAULT = {
    16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h00ff, 16'h0704,
    16'h4046, 16'hfaf8, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000};

  typedef enum logic [1:0] {MD_INIT, MD_NORM, MD_CMD} asp_mode_e;
  typedef enum logic [1:0] {H_IDLE, H_SEND, H_GAP, H_READ} asp_hst_e;

endpackage

// File: inc/asp_if.sv
// three-wire pins between host and sensor, with pull-up resolution
`timescale 1ns/1ns
`default_nettype none
interface asp_if;
  logic cs_n_out;
  logic cs_n_oe_n;
  logic sck_out;
  logic sck_oe_n;
  logic hd_out;
  logic hd_oe_n;
  logic dd_out;
  logic dd_oe_n;
  logic cs_n_lvl;
  logic clock_or_second_output_pin;
  logic data_lvl;

  // undriven select and clock read high through the weak pull-ups
  assign cs_n_lvl = cs_n_oe_n ? 1'b1 : cs_n_out; // RULE11
  assign clock_or_second_output_pin = sck_oe_n ? 1'b1 : sck_out; // RULE11
  assign data_lvl = !hd_oe_n ? hd_out : (!dd_oe_n ? dd_out : 1'b1);

  modport dev (
    input  cs_n_lvl, clock_or_second_output_pin, data_lvl,
    output dd_out, dd_oe_n
  );
  modport host (
    input  data_lvl,
    output cs_n_out, cs_n_oe_n, sck_out, sck_oe_n, hd_out, hd_oe_n
  );
endinterface
`default_nettype wire

// File: src/asp_dev.sv
// sensor end: sample fifo, mode selection, command port, output word
`timescale 1ns/1ns
`default_nettype none

// ********************************************************
// sample fifo, depth a power of two
// ********************************************************
module asp_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // clock, reset, enable
  input  wire logic         ref_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         ce_in,
  // fill side
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  // drain side
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_r [D];
  logic [AW:0]  wp_r;
  logic [AW:0]  rp_r;
  logic         full_w;
  logic         empty_w;

  assign empty_w = (wp_r == rp_r);
  assign full_w  = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
  assign in_ready_out  = !full_w;
  assign out_valid_out = !empty_w;
  assign out_data_out  = mem_r[rp_r[AW-1:0]];

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      wp_r <= '0;
      rp_r <= '0;
    end else if (ce_in) begin
      if (in_valid_in && !full_w) begin
        wp_r <= wp_r + 1'b1;
      end
      if (out_ready_in && !empty_w) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (ce_in && in_valid_in && !full_w) begin
      mem_r[wp_r[AW-1:0]] <= in_data_in;
    end
  end
endmodule

// ********************************************************
// sensor end
// ********************************************************
// Behaviour
// RULE1: two-bit status code, angle validity per code
// RULE2: angle 13 bits, 180 degrees full scale
// RULE3: temperature 7 bits, 2 C steps, -50 base
// RULE4: complement output inverts angle and temperature
// RULE5: normal operation by default after power-on
// RULE6: normal mode converts continuously using stored constants
// RULE7: normal mode sticks until next power-on reset
// RULE8: host holds select high, clock low at reset
// RULE9: host keeps request levels at least 1 ms
// RULE10: any other levels or break give normal
// RULE11: pins pulled up, host drives clock low
// RULE12: configuration is sixteen 16-bit stored words
// RULE13: command 0n plus 16 bits writes word
// RULE14: host sends command 1n to read word
// RULE15: next select shifts addressed word out
// RULE16: stored words copied into RAM at power-on
// RULE17: host leaves calibrated words 0,1,5,C,D,E alone
// RULE18: host leaves production words A, B alone
// RULE19: A holds date code, B lot number
// RULE20: unknown command codes ignored, RAM unchanged
module asp_dev #(
  parameter int                           INIT_CYC = asp_pkg::INIT_CYC_DEF,
  parameter logic [asp_pkg::NV_BITS-1:0]  NV_IMAGE = asp_pkg::NV_DEFAULT
) (
  // clock, reset, enable
  input  wire logic                      ref_clk_in,
  input  wire logic                      rst_n_in,
  input  wire logic                      ce_in,
  // serial pins
  asp_if.dev                             pins,
  // raw samples
  input  wire logic                      smp_valid_in,
  output logic                           smp_ready_out,
  input  wire logic [asp_pkg::ANG_W-1:0] smp_angle_in,
  input  wire logic [asp_pkg::TMP_W-1:0] smp_temp_in,
  input  wire logic                      smp_diag_gen_in,
  input  wire logic                      smp_diag_inp_in,
  // output word
  output logic                           out_valid_out,
  input  wire logic                      out_ready_in,
  output logic [asp_pkg::ANG_W-1:0]      out_angle_out,
  output logic [asp_pkg::TMP_W-1:0]      out_temp_out,
  output logic [asp_pkg::ERR_W-1:0]      out_err_out,
  output logic                           out_angle_ok_out,
  // mode
  output logic                           mode_norm_out,
  output logic                           mode_cmd_out
);
  import asp_pkg::*;

  localparam int CW = $clog2(INIT_CYC + 1);
  localparam int BW = $clog2(FRAME_W + 1);

  function automatic logic op_is(input logic [CMD_W-1:0] c,
                                 input logic [3:0] op);
    op_is = (c[CMD_W-1:ADDR_W] == op);
  endfunction

  // ********************************************************
  // pin synchronisers, change taken when stages 2 and 3 agree
  // ********************************************************
  logic [2:0] pin_w;
  logic [2:0] s1_r;
  logic [2:0] s2_r;
  logic [2:0] s3_r;
  logic [2:0] flt_r;
  logic [2:0] prv_r;

  assign pin_w = {pins.data_lvl, pins.clock_or_second_output_pin,
                  pins.cs_n_lvl};

  always_ff @(posedge ref_clk_in) begin
    if (ce_in) begin
      s1_r  <= pin_w;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      flt_r <= (s2_r & ~(s2_r ^ s3_r)) | (flt_r & (s2_r ^ s3_r));
      prv_r <= flt_r;
    end
  end

  logic cs_fall;
  logic cs_end;
  logic sck_rise;
  logic sck_fall;
  logic dat;

  assign cs_fall  = prv_r[PIN_CS] && !flt_r[PIN_CS];
  assign cs_end   = !prv_r[PIN_CS] && flt_r[PIN_CS];
  assign sck_rise = !prv_r[PIN_SCK] && flt_r[PIN_SCK];
  assign sck_fall = prv_r[PIN_SCK] && !flt_r[PIN_SCK];
  assign dat      = flt_r[PIN_DAT];

  // ********************************************************
  // mode selection after power-on
  // ********************************************************
  asp_mode_e       mode_r;
  logic [CW-1:0]   init_cnt_r;
  logic            req_lvl;
  logic            in_cmd;
  logic            in_norm;

  assign req_lvl = flt_r[PIN_CS] && !flt_r[PIN_SCK];
  assign in_cmd  = (mode_r == MD_CMD);
  assign in_norm = (mode_r == MD_NORM);
  assign mode_cmd_out  = in_cmd;
  assign mode_norm_out = in_norm;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      mode_r     <= MD_INIT;
      init_cnt_r <= '0;
    end else if (ce_in) begin
      case (mode_r)
        MD_INIT: begin
          if (!req_lvl) begin
            mode_r <= MD_NORM; // RULE5 RULE8 RULE10
          end else if (init_cnt_r == CW'(INIT_CYC - 1)) begin
            mode_r <= MD_CMD; // RULE9
          end else begin
            init_cnt_r <= init_cnt_r + 1'b1;
          end
        end
        MD_NORM: mode_r <= MD_NORM; // RULE7
        MD_CMD:  mode_r <= MD_CMD;
        default: mode_r <= MD_NORM;
      endcase
    end
  end

  // ********************************************************
  // configuration RAM
  // ********************************************************
  logic [WORD_W-1:0] ram_r [WORDS];
  logic [BW-1:0]     bit_cnt_r;
  logic [CMD_W-1:0]  cmd_r;
  logic [WORD_W-2:0] shr_r;
  logic              rd_pend_r;
  logic [ADDR_W-1:0] rd_addr_r;
  logic              rd_frm_r;
  logic              rx_bit;
  logic              cmd_done;
  logic [CMD_W-1:0]  cmd_byte;
  logic              wr_go;

  assign rx_bit   = in_cmd && !flt_r[PIN_CS] && sck_rise && !rd_frm_r;
  assign cmd_done = rx_bit && (bit_cnt_r == BW'(CMD_W - 1));
  assign cmd_byte = {shr_r[CMD_W-2:0], dat};
  assign wr_go    = rx_bit && (bit_cnt_r == BW'(FRAME_W - 1))
                    && op_is(cmd_r, OP_WR); // RULE20

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < WORDS; i++) begin
        ram_r[i] <= NV_IMAGE[i*WORD_W +: WORD_W]; // RULE12 RULE16
      end
    end else if (ce_in && wr_go) begin
      ram_r[cmd_r[ADDR_W-1:0]] <= {shr_r, dat}; // RULE13
    end
  end

  // ********************************************************
  // command receive
  // ********************************************************
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      bit_cnt_r <= '0;
      cmd_r     <= '0;
      shr_r     <= '0;
      rd_pend_r <= 1'b0;
      rd_addr_r <= '0;
      rd_frm_r  <= 1'b0;
    end else if (ce_in) begin
      if (in_cmd && cs_fall) begin
        bit_cnt_r <= '0;
        rd_frm_r  <= rd_pend_r;
      end else if (rx_bit) begin
        shr_r <= {shr_r[WORD_W-3:0], dat};
        if (bit_cnt_r != BW'(FRAME_W)) begin
          bit_cnt_r <= bit_cnt_r + 1'b1;
        end
      end
      if (cmd_done) begin
        cmd_r <= cmd_byte;
      end
      if (cmd_done && op_is(cmd_byte, OP_RD)) begin
        rd_pend_r <= 1'b1; // RULE15
        rd_addr_r <= cmd_byte[ADDR_W-1:0];
      end else if (cs_end && rd_frm_r) begin
        rd_pend_r <= 1'b0;
      end
      if (cs_end) begin
        rd_frm_r <= 1'b0;
      end
    end
  end

  // ********************************************************
  // read-back shifter, next bit after each falling clock
  // ********************************************************
  logic [WORD_W-1:0] tx_r;
  logic              drv_r;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      tx_r  <= '0;
      drv_r <= 1'b0;
    end else if (ce_in) begin
      if (in_cmd && cs_fall && rd_pend_r) begin
        tx_r  <= ram_r[rd_addr_r]; // RULE15
        drv_r <= 1'b1;
      end else if (drv_r && sck_fall) begin
        tx_r <= {tx_r[WORD_W-2:0], 1'b0};
      end
      if (cs_end) begin
        drv_r <= 1'b0;
      end
    end
  end

  assign pins.dd_out  = tx_r[WORD_W-1];
  assign pins.dd_oe_n = !drv_r;

  // ********************************************************
  // normal operation: samples to output word
  // ********************************************************
  logic             f_valid;
  logic [SMP_W-1:0] f_data;
  logic             pop;
  logic [ANG_W-1:0] ang_w;
  logic [TMP_W-1:0] tmp_w;
  logic             hot_w;
  logic             cpl_w;
  logic [ERR_W-1:0] err_w;

  asp_fifo #(
    .W (SMP_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in    (ref_clk_in),
    .rst_n_in      (rst_n_in),
    .ce_in         (ce_in),
    .in_valid_in   (smp_valid_in),
    .in_ready_out  (smp_ready_out),
    .in_data_in    ({smp_angle_in, smp_temp_in, smp_diag_gen_in,
                     smp_diag_inp_in}),
    .out_valid_out (f_valid),
    .out_ready_in  (pop),
    .out_data_out  (f_data)
  );

  assign pop   = in_norm && (!out_valid_out || out_ready_in); // RULE6
  assign ang_w = f_data[SMP_W-1 -: ANG_W]
                 - ram_r[ADR_ZERO][WORD_W-1:ZERO_LSB]; // RULE2
  assign tmp_w = f_data[2 +: TMP_W];
  assign hot_w = ({tmp_w, 1'b0} >= ram_r[ADR_TEMP][7:0]); // RULE3
  assign cpl_w = ram_r[ADR_CTRL1][CTRL1_CPL_BIT];

  always_comb begin
    if (f_data[1]) begin
      err_w = ERR_DIAG; // RULE1
    end else if (f_data[0]) begin
      err_w = ERR_INPUT; // RULE1
    end else if (hot_w) begin
      err_w = ERR_TEMP; // RULE1
    end else begin
      err_w = ERR_NONE;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      out_valid_out    <= 1'b0;
      out_angle_out    <= '0;
      out_temp_out     <= '0;
      out_err_out      <= ERR_NONE;
      out_angle_ok_out <= 1'b0;
    end else if (ce_in) begin
      if (pop) begin
        out_valid_out <= f_valid;
      end
      if (pop && f_valid) begin
        out_angle_out    <= cpl_w ? ~ang_w : ang_w; // RULE4
        out_temp_out     <= cpl_w ? ~tmp_w : tmp_w; // RULE4
        out_err_out      <= err_w;
        out_angle_ok_out <= !(f_data[1] || f_data[0]); // RULE1
      end
    end
  end
endmodule
`default_nettype wire

// File: src/asp_host.sv
// host end: mode request and serial command frames
`timescale 1ns/1ns
`default_nettype none
module asp_host #(
  parameter int INIT_CYC = asp_pkg::INIT_CYC_DEF,
  parameter int HALF_CYC = asp_pkg::SCLK_HALF_CYC
) (
  // clock, reset, enable
  input  wire logic                       ref_clk_in,
  input  wire logic                       rst_n_in,
  input  wire logic                       ce_in,
  // serial pins
  asp_if.host                             pins,
  // command-mode request level
  input  wire logic                       mode_req_in,
  // commands
  input  wire logic                       cmd_valid_in,
  output logic                            cmd_ready_out,
  input  wire logic                       cmd_rd_in,
  input  wire logic [asp_pkg::ADDR_W-1:0] cmd_addr_in,
  input  wire logic [asp_pkg::WORD_W-1:0] cmd_wdata_in,
  output logic                            cmd_rej_out,
  // read answers
  output logic                            rsp_valid_out,
  output logic [asp_pkg::WORD_W-1:0]      rsp_data_out
);
  import asp_pkg::*;

  localparam int HW = $clog2(INIT_CYC + 1);
  localparam int TW = $clog2(HALF_CYC + 1);
  localparam int NW = $clog2(FRAME_W + 1);

  // ********************************************************
  // data pin synchroniser
  // ********************************************************
  logic d1_r;
  logic d2_r;
  logic d3_r;
  logic dflt_r;

  always_ff @(posedge ref_clk_in) begin
    if (ce_in) begin
      d1_r <= pins.data_lvl;
      d2_r <= d1_r;
      d3_r <= d2_r;
      if (d2_r == d3_r) begin
        dflt_r <= d3_r;
      end
    end
  end

  // ********************************************************
  // request hold time before the first frame
  // ********************************************************
  logic [HW-1:0] hold_r;
  logic          held;

  assign held = (hold_r == HW'(INIT_CYC));

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      hold_r <= '0;
    end else if (ce_in) begin
      if (!mode_req_in) begin
        hold_r <= '0;
      end else if (!held) begin
        hold_r <= hold_r + 1'b1; // RULE9
      end
    end
  end

  // ********************************************************
  // frame sequencer
  // ********************************************************
  asp_hst_e            st_r;
  logic [TW-1:0]       tmr_r;
  logic                sck_r;
  logic                cs_r;
  logic [FRAME_W-1:0]  sh_r;
  logic [NW-1:0]       nb_r;
  logic                rd_r;
  logic [WORD_W-1:0]   rx_r;
  logic                tick;
  logic                prot;

  assign tick = (tmr_r == TW'(HALF_CYC - 1));
  assign prot = PROT_MASK[cmd_addr_in]; // RULE17 RULE18 RULE19
  assign cmd_ready_out = (st_r == H_IDLE) && mode_req_in && held;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      st_r          <= H_IDLE;
      tmr_r         <= '0;
      sck_r         <= 1'b0;
      cs_r          <= 1'b1;
      sh_r          <= '0;
      nb_r          <= '0;
      rd_r          <= 1'b0;
      rx_r          <= '0;
      rsp_valid_out <= 1'b0;
      rsp_data_out  <= '0;
      cmd_rej_out   <= 1'b0;
    end else if (ce_in) begin
      rsp_valid_out <= 1'b0;
      cmd_rej_out   <= 1'b0;
      tmr_r <= (st_r == H_IDLE || tick) ? '0 : tmr_r + 1'b1;
      case (st_r)
        H_IDLE: begin
          if (cmd_valid_in && cmd_ready_out) begin
            if (!cmd_rd_in && prot) begin
              cmd_rej_out <= 1'b1; // RULE17
            end else begin
              sh_r <= {cmd_rd_in ? OP_RD : OP_WR, cmd_addr_in,
                       cmd_wdata_in}; // RULE13 RULE14
              nb_r <= cmd_rd_in ? NW'(CMD_W) : NW'(FRAME_W);
              rd_r <= cmd_rd_in;
              cs_r <= 1'b0;
              st_r <= H_SEND;
            end
          end
        end
        H_SEND: begin
          if (tick) begin
            sck_r <= !sck_r;
            if (sck_r) begin
              sh_r <= {sh_r[FRAME_W-2:0], 1'b0};
              nb_r <= nb_r - 1'b1;
              if (nb_r == NW'(1)) begin
                cs_r <= 1'b1;
                st_r <= H_GAP;
              end
            end
          end
        end
        H_GAP: begin
          if (tick) begin
            if (rd_r) begin
              rd_r <= 1'b0;
              cs_r <= 1'b0;
              nb_r <= NW'(WORD_W);
              st_r <= H_READ;
            end else begin
              st_r <= H_IDLE;
            end
          end
        end
        H_READ: begin
          if (tick) begin
            sck_r <= !sck_r;
            if (!sck_r) begin
              rx_r <= {rx_r[WORD_W-2:0], dflt_r};
            end else begin
              nb_r <= nb_r - 1'b1;
              if (nb_r == NW'(1)) begin
                cs_r          <= 1'b1;
                rsp_valid_out <= 1'b1;
                rsp_data_out  <= rx_r;
                st_r          <= H_GAP;
              end
            end
          end
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  // idle levels: select high, clock actively low while requesting
  assign pins.cs_n_out  = cs_r; // RULE8
  assign pins.cs_n_oe_n = !mode_req_in;
  assign pins.sck_out   = sck_r; // RULE8
  assign pins.sck_oe_n  = !mode_req_in; // RULE11
  assign pins.hd_out    = sh_r[FRAME_W-1];
  assign pins.hd_oe_n   = (st_r != H_SEND);
endmodule
`default_nettype wire

// File: bench/asp_chk.sv
// link checker between host end and sensor end
`timescale 1ns/1ns
`default_nettype none
module asp_chk (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // link signals
  input wire logic cs_n_out,
  input wire logic cs_n_oe_n,
  input wire logic sck_out,
  input wire logic sck_oe_n,
  input wire logic hd_oe_n,
  input wire logic dd_out,
  input wire logic dd_oe_n,
  input wire logic cs_n_lvl,
  input wire logic clock_or_second_output_pin
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_cs_pull;
    cs_n_oe_n |-> cs_n_lvl;
  endproperty
  a_cs_pull: assert property (p_cs_pull)
    else $error("released select not high");
  property p_sck_pull;
    sck_oe_n |-> clock_or_second_output_pin;
  endproperty
  a_sck_pull: assert property (p_sck_pull)
    else $error("released clock not high");
  property p_dev_rel;
    cs_n_lvl [*8] |-> dd_oe_n;
  endproperty
  a_dev_rel: assert property (p_dev_rel)
    else $error("sensor drives data while deselected");
  property p_no_fight;
    !dd_oe_n |-> hd_oe_n;
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("both ends drive data");
  property p_idle_low;
    $fell(cs_n_lvl) |-> !clock_or_second_output_pin;
  endproperty
  a_idle_low: assert property (p_idle_low)
    else $error("clock not low at frame start");
  property p_sck_in_frame;
    $rose(sck_out) && !sck_oe_n |-> !cs_n_out;
  endproperty
  a_sck_in_frame: assert property (p_sck_in_frame)
    else $error("clock edge outside frame");
  property p_dev_hold;
    !dd_oe_n && clock_or_second_output_pin
      && $past(clock_or_second_output_pin) |-> $stable(dd_out);
  endproperty
  a_dev_hold: assert property (p_dev_hold)
    else $error("read bit moved while clock high");
  property p_gap;
    $rose(cs_n_out) && !cs_n_oe_n |-> cs_n_out [*8];
  endproperty
  a_gap: assert property (p_gap)
    else $error("select gap too short");
endmodule
`default_nettype wire

// File: bench/asp_tb_top.sv
// self-checking bench: both ends, mode entry, ram access, sample path
`timescale 1ns/1ns
`default_nettype none
module angle_sensor_command_port_tb_top;
  import asp_pkg::*;
  localparam int INIT = 64;
  localparam logic [12:0] ANGS [4] = '{13'h1abc, 13'h0001, 13'h1fff, 13'h0};
  localparam logic [6:0]  TMPS [4] = '{7'h10, 7'h05, 7'h7c, 7'h7b};
  logic        ref_clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        mode_req_in = 1'b0;
  logic        cmd_valid_in = 1'b0;
  logic        cmd_rd_in = 1'b0;
  logic [3:0]  cmd_addr_in = 4'h0;
  logic [15:0] cmd_wdata_in = 16'h0000;
  logic        smp_valid_in = 1'b0;
  logic [12:0] smp_angle_in = 13'h0;
  logic [6:0]  smp_temp_in = 7'h0;
  logic        smp_gen_in = 1'b0;
  logic        smp_inp_in = 1'b0;
  logic        out_ready_in = 1'b0;
  logic        cmd_ready_out;
  logic        cmd_rej_out;
  logic        rsp_valid_out;
  logic [15:0] rsp_data_out;
  logic        smp_ready_out;
  logic        out_valid_out;
  logic [12:0] out_angle_out;
  logic [6:0]  out_temp_out;
  logic [1:0]  out_err_out;
  logic        out_ok_out;
  logic        mode_norm_out;
  logic        mode_cmd_out;
  int          err_total = 0;
  int          n_tests = 0;
  wire  [15:0] md = {14'h0, mode_norm_out, mode_cmd_out};

  always #10 ref_clk_in = ~ref_clk_in;

  asp_if u_asp_if ();
  asp_dev #(.INIT_CYC(INIT)) u_asp_dev (.ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in), .ce_in(1'b1), .pins(u_asp_if),
    .smp_valid_in(smp_valid_in), .smp_ready_out(smp_ready_out),
    .smp_angle_in(smp_angle_in), .smp_temp_in(smp_temp_in),
    .smp_diag_gen_in(smp_gen_in), .smp_diag_inp_in(smp_inp_in),
    .out_valid_out(out_valid_out), .out_ready_in(out_ready_in),
    .out_angle_out(out_angle_out), .out_temp_out(out_temp_out),
    .out_err_out(out_err_out), .out_angle_ok_out(out_ok_out),
    .mode_norm_out(mode_norm_out), .mode_cmd_out(mode_cmd_out));
  asp_host #(.INIT_CYC(INIT), .HALF_CYC(10)) u_asp_host (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
    .pins(u_asp_if), .mode_req_in(mode_req_in),
    .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out),
    .cmd_rd_in(cmd_rd_in), .cmd_addr_in(cmd_addr_in),
    .cmd_wdata_in(cmd_wdata_in), .cmd_rej_out(cmd_rej_out),
    .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out));
  asp_chk u_asp_chk (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .cs_n_out(u_asp_if.cs_n_out), .cs_n_oe_n(u_asp_if.cs_n_oe_n),
    .sck_out(u_asp_if.sck_out), .sck_oe_n(u_asp_if.sck_oe_n),
    .hd_oe_n(u_asp_if.hd_oe_n), .dd_out(u_asp_if.dd_out),
    .dd_oe_n(u_asp_if.dd_oe_n), .cs_n_lvl(u_asp_if.cs_n_lvl),
    .clock_or_second_output_pin(u_asp_if.clock_or_second_output_pin));

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      err_total++;
      $display("BAD wait expected done seen timeout");
      summarize();
    end
  endtask
  task automatic do_reset(input logic req);
    mode_req_in = req;
    rst_n_in = 1'b0;
    repeat (4) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
  endtask
  // one command, held until taken
  task automatic host_cmd(input logic rd, input logic [3:0] a,
                          input logic [15:0] d, output logic rej);
    int n;
    @(negedge ref_clk_in);
    cmd_valid_in = 1'b1;
    cmd_rd_in = rd;
    cmd_addr_in = a;
    cmd_wdata_in = d;
    n = 0;
    while (cmd_ready_out !== 1'b1 && n < 3000) begin
      @(negedge ref_clk_in);
      n++;
    end
    tmo(n, 3000);
    @(negedge ref_clk_in);
    cmd_valid_in = 1'b0;
    rej = cmd_rej_out;
  endtask
  task automatic host_rd(input logic [3:0] a, output logic [15:0] q);
    logic r;
    int   n;
    host_cmd(1'b1, a, 16'h0000, r);
    n = 0;
    while (rsp_valid_out !== 1'b1 && n < 3000) begin
      @(negedge ref_clk_in);
      n++;
    end
    tmo(n, 3000);
    q = rsp_data_out;
  endtask
  task automatic t_cmd();
    logic [15:0] q;
    logic        r;
    int          n;
    do_reset(1'b1);
    repeat (INIT - 8) @(negedge ref_clk_in);
    chk("mode_early", 16'h0, md);
    n = 0;
    while (mode_cmd_out !== 1'b1 && n < 60) begin
      @(negedge ref_clk_in);
      n++;
    end
    tmo(n, 60);
    chk("mode_cmd", 16'h1, md);
    host_rd(4'h6, q);
    chk("word6", 16'hfaf8, q);
    host_rd(4'h7, q);
    chk("word7", 16'h4046, q);
    host_cmd(1'b0, 4'h3, 16'h1234, r);
    chk("rej3", 16'h0, {15'h0, r});
    host_rd(4'h3, q);
    chk("word3", 16'h1234, q);
    host_cmd(1'b0, 4'h0, 16'hbeef, r);
    chk("rej0", 16'h1, {15'h0, r});
    host_rd(4'h0, q);
    chk("word0", 16'h0000, q);
    smp_valid_in = 1'b1;
    n = 0;
    repeat (20) begin
      if (smp_ready_out === 1'b1) n++;
      @(negedge ref_clk_in);
    end
    smp_valid_in = 1'b0;
    chk("fill", 16'd16, n[15:0]);
    chk("held", 16'h0, {15'h0, out_valid_out});
    $display("test command mode done");
  endtask
  task automatic t_norm();
    int n;
    do_reset(1'b1);
    repeat (10) @(negedge ref_clk_in);
    mode_req_in = 1'b0;
    repeat (INIT + 20) @(negedge ref_clk_in);
    chk("mode_brk", 16'h2, md);
    do_reset(1'b0);
    repeat (4) @(negedge ref_clk_in);
    chk("mode_def", 16'h2, md);
    for (int i = 0; i < 4; i++) begin
      smp_valid_in = 1'b1;
      smp_angle_in = ANGS[i];
      smp_temp_in = TMPS[i];
      smp_gen_in = (i == 0);
      smp_inp_in = (i == 1);
      @(negedge ref_clk_in);
    end
    smp_valid_in = 1'b0;
    repeat (4) @(negedge ref_clk_in);
    out_ready_in = 1'b1;
    for (int i = 0; i < 4; i++) begin
      n = 0;
      while (out_valid_out !== 1'b1 && n < 50) begin
        @(negedge ref_clk_in);
        n++;
      end
      tmo(n, 50);
      chk("angle", {3'h0, ANGS[i]}, {3'h0, out_angle_out});
      chk("temp", {9'h0, TMPS[i]}, {9'h0, out_temp_out});
      chk("err", i[15:0], {14'h0, out_err_out});
      chk("ok", {15'h0, i > 1}, {15'h0, out_ok_out});
      @(negedge ref_clk_in);
    end
    chk("drained", 16'h0, {15'h0, out_valid_out});
    mode_req_in = 1'b1;
    repeat (INIT + 20) @(negedge ref_clk_in);
    chk("mode_stick", 16'h2, md);
    $display("test normal mode done");
  endtask

  initial begin
    @(negedge ref_clk_in);
    t_cmd();
    t_norm();
    summarize();
  end
endmodule
`default_nettype wire
